// ---- hdl/dds_device.sv ----
// Overview of operation
// - Output frequency is fraction of master clock
// - Capture one data bit per serial falling edge
// - Host sends each transfer as 16-bit word
// - Frame strobe low starts a new word
// - Accumulator uses frequency word 0 or 1
// - Frequency choice from pin or internal bit
// - Frequency pin sampled on master rising edges
// - Host changes select pins away from edges
// - Four phase offsets added before sine table
// - Phase choice from pins or internal bits
// - Phase pins sampled on master rising edges
// - Unused select pins held low by board
// - Frequency word 0 is 32 bits
// - Frequency word 1 is 32 bits
// - Phase words 12 bits, choice low/high decode
// - Four-bit address selects byte slice destination
// - Word is command, address, eight data bits
// - Defer holds byte; full write commits sixteen frequency bits or twelve phase bits
// - Source bit picks internal bits or pins
// - Sync bit adds two master cycles latency
`timescale 1ns/1ps
module dds_device (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    dds_link_if.dev_mp link,
    input wire logic freq_word_choice_in,
    input wire logic phase_choice_low_in,
    input wire logic phase_choice_high_in,
    output logic [dds_pkg::PHASE_W-1:0] sine_lookup_addr_out,
    output logic [dds_pkg::FREQ_W-1:0] phase_acc_out,
    output logic sleep_out
);
    import dds_pkg::*;

    function automatic logic [FREQ_W-1:0] put_byte(
        input logic [FREQ_W-1:0] old_val,
        input logic [1:0] idx,
        input logic [BYTE_W-1:0] val
    );
        logic [FREQ_W-1:0] res;
        res = old_val;
        res[idx*BYTE_W +: BYTE_W] = val;
        return res;
    endfunction : put_byte

    ////////////////////////////////////////////////////////////////////////
    // Serial clock domain
    // Link clock stops between frames, so no reset here; power-up values
    logic [CNT_W-1:0] bit_cnt_r = 4'h0;
    logic [WORD_W-1:0] shift_r = 16'h0000;
    logic [WORD_W-1:0] word_r = 16'h0000;
    logic word_tog_r = 1'b0;

    always_ff @(negedge link.serial_clk or posedge link.word_frame_strobe_n) begin
        if (link.word_frame_strobe_n) begin
            bit_cnt_r <= 4'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    always_ff @(negedge link.serial_clk) begin
        if (!link.word_frame_strobe_n) begin
            shift_r <= {shift_r[WORD_W-2:0], link.serial_word_input};
            if (bit_cnt_r == LAST_BIT) begin
                word_r <= {shift_r[WORD_W-2:0], link.serial_word_input};
                word_tog_r <= ~word_tog_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Word arrival crossing into master clock domain
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic word_ev;

    // word_r is stable for at least 15 serial edges after the toggle
    always_ff @(posedge ref_clk_in) begin
        tog_s1_r <= word_tog_r;
        tog_s2_r <= tog_s1_r;
        tog_s3_r <= tog_s2_r;
    end

    assign word_ev = reset_n_in && (tog_s2_r ^ tog_s3_r);

    ////////////////////////////////////////////////////////////////////////
    // Optional two-cycle alignment of word loading
    logic sync_r;
    logic [1:0] pend_v_r;
    logic [WORD_W-1:0] pend_w_r [2];
    logic apply_v;
    logic [WORD_W-1:0] apply_w;
    logic [CMD_W-1:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] dat;

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pend_v_r <= 2'h0;
        end else begin
            pend_v_r <= {pend_v_r[0], word_ev};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        pend_w_r[0] <= word_r;
        pend_w_r[1] <= pend_w_r[0];
    end

    assign apply_v = sync_r ? pend_v_r[1] : word_ev;
    assign apply_w = sync_r ? pend_w_r[1] : word_r;
    assign cmd = apply_w[CMD_LSB +: CMD_W];
    assign addr = apply_w[ADDR_LSB +: ADDR_W];
    assign dat = apply_w[BYTE_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Defer byte and destination registers
    logic [BYTE_W-1:0] defer_r;
    logic [FREQ_W-1:0] freq_r [NUM_FREQ];
    logic [PHASE_W-1:0] phase_r [NUM_PHASE];
    logic [FREQ_W-1:0] freq_new;
    logic [FREQ_W-1:0] phase_wide;

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            defer_r <= DEFER_RST;
        end else if (apply_v && (cmd == CMD_PH_DEFER || cmd == CMD_FR_DEFER)) begin
            defer_r <= dat;
        end
    end

    // Present byte goes to its address, deferred byte to the partner slice
    always_comb begin
        freq_new = put_byte(put_byte(freq_r[addr[2]], addr[1:0], dat), addr[1:0] ^ 2'h1, defer_r);
        phase_wide = put_byte(put_byte({20'h0_0000, phase_r[addr[2:1]]}, {1'b0, addr[0]}, dat),
                              {1'b0, ~addr[0]}, defer_r);
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_FREQ; i++) begin
                freq_r[i] <= FREQ_RST;
            end
            for (int i = 0; i < NUM_PHASE; i++) begin
                phase_r[i] <= PHASE_RST;
            end
        end else if (apply_v) begin
            // Address and command kinds that disagree are ignored
            if (cmd == CMD_FR_FULL && !addr[3]) begin
                freq_r[addr[2]] <= freq_new;
            end
            if (cmd == CMD_PH_FULL && addr[3]) begin
                // Top nibble of the high byte is dropped
                phase_r[addr[2:1]] <= phase_wide[PHASE_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and internal select bits
    logic src_r;
    logic acc_clr_r;
    logic sleep_r;
    logic fsel_bit_r;
    logic [1:0] psel_bits_r;

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            fsel_bit_r <= 1'b0;
            psel_bits_r <= 2'h0;
        end else if (apply_v) begin
            if (cmd == CMD_SEL_PH || cmd == CMD_SEL_BOTH) begin
                psel_bits_r <= {apply_w[SEL_PH_HI_BIT], apply_w[SEL_PH_LO_BIT]};
            end
            if (cmd == CMD_SEL_FR || cmd == CMD_SEL_BOTH) begin
                fsel_bit_r <= apply_w[SEL_FR_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            sync_r <= 1'b0;
            src_r <= 1'b0;
            sleep_r <= 1'b0;
            acc_clr_r <= 1'b0;
        end else if (apply_v) begin
            if (cmd[3:2] == GRP_CTL) begin
                sync_r <= apply_w[SYNC_BIT];
                src_r <= apply_w[SRC_BIT];
            end
            if (cmd[3:2] == GRP_PWR) begin
                sleep_r <= apply_w[SLEEP_BIT];
                acc_clr_r <= apply_w[ACC_CLR_BIT];
                // Clear is a one-shot, never stored
                if (apply_w[CTL_CLR_BIT]) begin
                    sync_r <= 1'b0;
                    src_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Select pins: two-flop synchroniser, two more stages with sync set
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_d1_r;
    logic [2:0] pin_d2_r;
    logic [2:0] pin_sel;
    logic eff_fsel;
    logic [1:0] eff_psel;

    // Pin edge near a clock edge lands one cycle early or late
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            pin_d1_r <= 3'h0;
            pin_d2_r <= 3'h0;
        end else begin
            pin_s1_r <= {phase_choice_high_in, phase_choice_low_in, freq_word_choice_in};
            pin_s2_r <= pin_s1_r;
            pin_d1_r <= pin_s2_r;
            pin_d2_r <= pin_d1_r;
        end
    end

    assign pin_sel = sync_r ? pin_d2_r : pin_s2_r;
    assign eff_fsel = src_r ? fsel_bit_r : pin_sel[0];
    assign eff_psel = src_r ? psel_bits_r : pin_sel[2:1];

    ////////////////////////////////////////////////////////////////////////
    // Phase accumulator and sine table address
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in || acc_clr_r) begin
            phase_acc_out <= FREQ_RST;
        end else if (!sleep_r) begin
            phase_acc_out <= phase_acc_out + freq_r[eff_fsel];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            sine_lookup_addr_out <= PHASE_RST;
            sleep_out <= 1'b0;
        end else begin
            sleep_out <= sleep_r;
            if (!sleep_r) begin
                sine_lookup_addr_out <= phase_acc_out[FREQ_W-1 -: PHASE_W] + phase_r[eff_psel];
            end
        end
    end
endmodule : dds_device

// ---- hdl/dds_host.sv ----
`timescale 1ns/1ps
module dds_host #(
    parameter logic [dds_pkg::DIV_W-1:0] HALF_CYCLES = dds_pkg::HOST_HALF_DEFAULT
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [dds_pkg::WORD_W-1:0] cmd_word_in,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    dds_link_if.host_mp link
);
    import dds_pkg::*;

    dds_host_state_t state_r;
    logic [DIV_W-1:0] div_r;
    logic tick;
    logic [WORD_W-1:0] tx_r;
    logic [CNT_W-1:0] bits_r;
    logic sclk_r;
    logic data_r;
    logic frame_n_r;

    assign link.serial_clk = sclk_r;
    assign link.serial_word_input = data_r;
    assign link.word_frame_strobe_n = frame_n_r;

    ////////////////////////////////////////////////////////////////////////
    // Serial clock divider, halted while idle
    assign tick = (div_r == HALF_CYCLES - 8'h01);

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in || state_r == DDS_H_IDLE || tick) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer: data changes on rising edges, device takes falling
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state_r <= DDS_H_IDLE;
            cmd_ready_out <= 1'b0;
            sclk_r <= 1'b1;
            data_r <= 1'b0;
            frame_n_r <= 1'b1;
            tx_r <= 16'h0000;
            bits_r <= 4'h0;
        end else begin
            unique case (state_r)
                DDS_H_IDLE: begin
                    cmd_ready_out <= 1'b1;
                    if (cmd_valid_in && cmd_ready_out) begin
                        tx_r <= cmd_word_in;
                        data_r <= cmd_word_in[WORD_W-1];
                        frame_n_r <= 1'b0;
                        bits_r <= 4'h0;
                        cmd_ready_out <= 1'b0;
                        state_r <= DDS_H_SHIFT;
                    end
                end
                DDS_H_SHIFT: begin
                    if (tick) begin
                        sclk_r <= ~sclk_r;
                        if (!sclk_r) begin
                            if (bits_r == LAST_BIT) begin
                                frame_n_r <= 1'b1;
                                state_r <= DDS_H_GAP;
                            end else begin
                                bits_r <= bits_r + 4'h1;
                                tx_r <= {tx_r[WORD_W-2:0], 1'b0};
                                data_r <= tx_r[WORD_W-2];
                            end
                        end
                    end
                end
                DDS_H_GAP: begin
                    // Strobe stays high a half period between words
                    if (tick) begin
                        cmd_ready_out <= 1'b1;
                        state_r <= DDS_H_IDLE;
                    end
                end
                default: begin
                    state_r <= DDS_H_IDLE;
                end
            endcase
        end
    end
endmodule : dds_host

// ---- hdl/dds_link_if.sv ----
`timescale 1ns/1ps
interface dds_link_if;
    logic serial_clk;
    logic serial_word_input;
    logic word_frame_strobe_n;

    modport host_mp (
        output serial_clk,
        output serial_word_input,
        output word_frame_strobe_n
    );

    modport dev_mp (
        input serial_clk,
        input serial_word_input,
        input word_frame_strobe_n
    );
endinterface : dds_link_if

// ---- hdl/dds_pkg.sv ----
package dds_pkg;
    // Serial word layout, sent most significant bit first
    localparam int WORD_W = 16;
    localparam int CMD_W = 4;
    localparam int ADDR_W = 4;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 4;
    localparam int CMD_LSB = 12;
    localparam int ADDR_LSB = 8;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;

    // Register widths and reset values
    localparam int FREQ_W = 32;
    localparam int PHASE_W = 12;
    localparam int NUM_FREQ = 2;
    localparam int NUM_PHASE = 4;
    localparam logic [FREQ_W-1:0] FREQ_RST = 32'h0000_0000;
    localparam logic [PHASE_W-1:0] PHASE_RST = 12'h000;
    localparam logic [BYTE_W-1:0] DEFER_RST = 8'h00;

    // Command codes in the top nibble
    localparam logic [CMD_W-1:0] CMD_PH_FULL = 4'h0;
    localparam logic [CMD_W-1:0] CMD_PH_DEFER = 4'h1;
    localparam logic [CMD_W-1:0] CMD_FR_FULL = 4'h2;
    localparam logic [CMD_W-1:0] CMD_FR_DEFER = 4'h3;
    localparam logic [CMD_W-1:0] CMD_SEL_PH = 4'h4;
    localparam logic [CMD_W-1:0] CMD_SEL_FR = 4'h5;
    localparam logic [CMD_W-1:0] CMD_SEL_BOTH = 4'h6;
    localparam logic [1:0] GRP_CTL = 2'h2;
    localparam logic [1:0] GRP_PWR = 2'h3;

    // Bit positions inside control and select words
    localparam int SYNC_BIT = 13;
    localparam int SRC_BIT = 12;
    localparam int SLEEP_BIT = 13;
    localparam int ACC_CLR_BIT = 12;
    localparam int CTL_CLR_BIT = 11;
    localparam int SEL_FR_BIT = 11;
    localparam int SEL_PH_HI_BIT = 10;
    localparam int SEL_PH_LO_BIT = 9;

    // Host serial clock divider: half period in reference cycles
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] HOST_HALF_DEFAULT = 8'h04;

    typedef enum logic [1:0] {
        DDS_H_IDLE = 2'b00,
        DDS_H_SHIFT = 2'b01,
        DDS_H_GAP = 2'b10
    } dds_host_state_t;
endpackage : dds_pkg

// ---- test/dds_link_props.sv ----
`timescale 1ns/1ps
module dds_link_props #(
    parameter int HALF = 4
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic serial_clk,
    input wire logic serial_word_input,
    input wire logic word_frame_strobe_n,
    input wire logic [dds_pkg::WORD_W-1:0] cmd_word_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_ready_out
);
    localparam int FRAME_LOW = 32 * HALF;
    logic [7:0] low_r;
    logic [11:0] frame_r;
    logic [4:0] fall_r;
    logic sclk_r;
    logic msb_r;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    ////////////////////////////////////////////////////////////
    // Counters cleared by idle levels, so a short frame shows up at its end
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            low_r <= 8'h00;
            frame_r <= 12'h000;
            fall_r <= 5'h00;
            sclk_r <= 1'b1;
            msb_r <= 1'b0;
        end else begin
            low_r <= serial_clk ? 8'h00 : low_r + 8'h01;
            frame_r <= word_frame_strobe_n ? 12'h000 : frame_r + 12'h001;
            fall_r <= word_frame_strobe_n ? 5'h00 : fall_r + 5'(sclk_r & ~serial_clk);
            sclk_r <= serial_clk;
            if (cmd_valid_in && cmd_ready_out) begin
                msb_r <= cmd_word_in[dds_pkg::WORD_W-1];
            end
        end
    end
    ////////////////////////////////////////////////////////////
    a_idle_clk_high: assert property (word_frame_strobe_n |-> serial_clk)
        else $error("serial clock low outside a frame");
    a_fall_in_frame: assert property ($fell(serial_clk) |-> !word_frame_strobe_n)
        else $error("serial clock fell with strobe high");
    a_low_half_period: assert property ($rose(serial_clk) |-> low_r == HALF)
        else $error("serial clock low phase wrong length");
    a_data_held_steady: assert property (!word_frame_strobe_n && $past(!word_frame_strobe_n)
        && !$rose(serial_clk) |-> $stable(serial_word_input)) else $error("data moved away from rising edge");
    a_sixteen_bits_sent: assert property ($rose(word_frame_strobe_n) |-> fall_r == 5'h10)
        else $error("frame did not carry sixteen bits");
    a_frame_length_exact: assert property ($rose(word_frame_strobe_n) |-> frame_r == FRAME_LOW)
        else $error("frame strobe low for wrong time");
    a_msb_goes_first: assert property ($fell(word_frame_strobe_n) |-> serial_word_input == msb_r)
        else $error("first bit is not bit fifteen");
    a_take_opens_frame: assert property (cmd_valid_in && cmd_ready_out |-> ##[1:3] !word_frame_strobe_n)
        else $error("accepted word did not open a frame");
    a_busy_in_frame: assert property (!word_frame_strobe_n |-> !cmd_ready_out)
        else $error("ready high during a frame");
    a_ready_after_gap: assert property ($rose(word_frame_strobe_n) |-> !cmd_ready_out ##[1:8] cmd_ready_out)
        else $error("ready not back after frame gap");
endmodule : dds_link_props

// ---- test/dds_serial_tuning_registers_bench.sv ----
`timescale 1ns/1ps
module dds_serial_tuning_registers_bench;
    import dds_pkg::*;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [WORD_W-1:0] cmd_word = 16'h0000;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic fsel = 1'b0;
    logic psel_lo = 1'b0;
    logic psel_hi = 1'b0;
    logic [PHASE_W-1:0] sine;
    logic [FREQ_W-1:0] acc;
    logic sleep;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [FREQ_W-1:0] fw [2];
    logic [PHASE_W-1:0] pw [4];
    logic [FREQ_W-1:0] exp_q [$];
    event meas_go;
    always #4 ref_clk_in = ~ref_clk_in;
    dds_link_if dds_link_if_i ();
    dds_host #(.HALF_CYCLES(8'h02)) dds_host_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .cmd_word_in(cmd_word), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .link(dds_link_if_i));
    dds_device dds_device_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .link(dds_link_if_i),
        .freq_word_choice_in(fsel), .phase_choice_low_in(psel_lo), .phase_choice_high_in(psel_hi),
        .sine_lookup_addr_out(sine), .phase_acc_out(acc), .sleep_out(sleep));
    dds_link_props #(.HALF(2)) dds_link_props_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .serial_clk(dds_link_if_i.serial_clk), .serial_word_input(dds_link_if_i.serial_word_input),
        .word_frame_strobe_n(dds_link_if_i.word_frame_strobe_n), .cmd_word_in(cmd_word),
        .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // Two edges first: ready only drops one edge after a take
    task automatic send(input logic [WORD_W-1:0] w);
        repeat (2) @(posedge ref_clk_in);
        while (cmd_ready !== 1'b1) @(posedge ref_clk_in);
        cmd_word <= w;
        cmd_valid <= 1'b1;
        @(posedge ref_clk_in);
        cmd_valid <= 1'b0;
    endtask : send
    task automatic settle();
        repeat (2) @(posedge ref_clk_in);
        while (cmd_ready !== 1'b1) @(posedge ref_clk_in);
        repeat (12) @(posedge ref_clk_in);
    endtask : settle
    task automatic expect_out(input logic [31:0] f, input logic [PHASE_W-1:0] p);
        settle();
        exp_q.push_back(f);
        exp_q.push_back({20'h0_0000, p});
        ->meas_go;
        repeat (4) @(posedge ref_clk_in);
    endtask : expect_out
    task automatic pins(input logic [2:0] c);
        // Non-blocking just after an edge keeps the switchover deterministic
        fsel <= c[2];
        psel_hi <= c[1];
        psel_lo <= c[0];
    endtask : pins
    // Pins move just after an edge; lag is edges until the measurement starts
    task automatic probe(input logic [2:0] c, input int lag, input logic [31:0] f, input logic [PHASE_W-1:0] p);
        @(posedge ref_clk_in);
        pins(c);
        repeat (lag) @(posedge ref_clk_in);
        exp_q.push_back(f);
        exp_q.push_back({20'h0_0000, p});
        ->meas_go;
        repeat (4) @(posedge ref_clk_in);
    endtask : probe
    ////////////////////////////////////////////////////////////
    initial begin : monitor
        logic [31:0] a;
        forever begin
            @(meas_go);
            @(posedge ref_clk_in);
            a = acc;
            @(posedge ref_clk_in);
            check(acc - a, exp_q.pop_front());
            check({20'h0_0000, sine - a[31:20]}, exp_q.pop_front());
        end
    end
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        logic [31:0] hold;
        logic [3:0] c;
        hold = $urandom(23);
        fw[0] = $urandom();
        fw[1] = $urandom();
        for (int j = 0; j < 4; j++) pw[j] = PHASE_W'($urandom());
        repeat (5) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        check(acc, 32'h0000_0000);
        check({20'h0_0000, sine}, 32'h0000_0000);
        check({31'h0, sleep}, 32'h0000_0000);
        // Defer then full write, byte pairs back to back
        for (int k = 0; k < 2; k++) begin
            send({CMD_FR_DEFER, 4'h0, fw[k][15:8]});
            send({CMD_FR_FULL, 1'b0, k[0], 2'b00, fw[k][7:0]});
            send({CMD_FR_DEFER, 4'h0, fw[k][31:24]});
            send({CMD_FR_FULL, 1'b0, k[0], 2'b10, fw[k][23:16]});
        end
        // Junk upper nibble must be dropped from each phase word
        for (int j = 0; j < 4; j++) begin
            send({CMD_PH_DEFER, 4'h0, 4'(~j), pw[j][11:8]});
            send({CMD_PH_FULL, 1'b1, 2'(j), 1'b0, pw[j][7:0]});
        end
        send({CMD_FR_FULL, 4'h8, 8'hFF});
        for (c = 0; c < 8; c++) begin
            pins(c[2:0]);
            expect_out(fw[c[2]], pw[c[1:0]]);
        end
        pins(3'b000);
        send(16'h9000);
        for (c = 0; c < 8; c++) begin
            if (c[0]) begin
                send({CMD_SEL_FR, c[2], 11'h000});
                send({CMD_SEL_PH, 1'b0, c[1:0], 9'h000});
            end else begin
                send({CMD_SEL_BOTH, c[2:0], 9'h000});
            end
            expect_out(fw[c[2]], pw[c[1:0]]);
        end
        send(16'hB000);
        send({CMD_SEL_BOTH, 3'b101, 9'h000});
        expect_out(fw[1], pw[1]);
        send(16'hC800);
        pins(3'b010);
        expect_out(fw[0], pw[2]);
        // Two-flop pin path: old word one edge after the change, new word after two
        probe(3'b110, 1, fw[0], pw[2]);
        probe(3'b010, 2, fw[0], pw[2]);
        send(16'hA000);
        settle();
        // Sync on: two more stages before the phase pins take effect
        probe(3'b011, 3, fw[0], pw[2]);
        probe(3'b010, 4, fw[0], pw[2]);
        send(16'hE000);
        settle();
        check({31'h0, sleep}, 32'h0000_0001);
        hold = acc;
        repeat (3) @(posedge ref_clk_in);
        check(acc, hold);
        send(16'hD000);
        settle();
        check(acc, 32'h0000_0000);
        send(16'hC000);
        expect_out(fw[0], pw[2]);
        complete_run();
    end
endmodule : dds_serial_tuning_registers_bench
